// ===== logic/ppc_pkg.sv
package ppc_pkg;

   // byte offsets on the management register interface
   localparam logic [7:0] PORT1_PHY_CONTROL_OFS   = 8'h1d;
   localparam logic [7:0] PORT1_LINK_STATUS_A_OFS = 8'h1e;
   localparam logic [7:0] PORT1_LINK_STATUS_B_OFS = 8'h1f;
   localparam logic [7:0] PORT2_PHY_CONTROL_OFS   = 8'h2d;
   localparam logic [7:0] PORT2_LINK_STATUS_A_OFS = 8'h2e;
   localparam logic [7:0] PORT2_LINK_STATUS_B_OFS = 8'h2f;
   localparam logic [7:0] PORT3_CONTROL_SLOT_OFS  = 8'h3d;
   localparam logic [7:0] PORT3_STATUS_A_SLOT_OFS = 8'h3e;
   localparam logic [7:0] PORT3_LINK_STATUS_B_OFS = 8'h3f;

   // control byte field positions
   localparam int CTL_LED_OFF     = 7;
   localparam int CTL_TX_DISABLE  = 6;
   localparam int CTL_AN_RESTART  = 5;
   localparam int CTL_FEF_DISABLE = 4;
   localparam int CTL_POWER_DOWN  = 3;
   localparam int CTL_MDIX_OFF    = 2;
   localparam int CTL_FORCE_MDI   = 1;
   localparam int CTL_RESERVED    = 0;

   // reset values and the blanked indicator level
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [3:0] LED_DARK       = 4'hf;

   // strap capture: edges after reset release before straps are taken
   localparam logic [1:0] STRAP_SETTLE   = 2'h2;

   // live PHY state of one copper/fiber port
   typedef struct packed {
      logic       mdix;          // 1 = crossover mode in use
      logic       an_done;       // auto-negotiation complete
      logic       link_good;     // link up
      logic       partner_pause; // partner advertised pause
      logic [3:0] partner_abil;  // 100fd, 100hd, 10fd, 10hd
   } ppc_phy_stat_s;

   // live MAC state of one port
   typedef struct packed {
      logic rx_fc;     // receive flow control active
      logic tx_fc;     // transmit flow control active
      logic speed100;  // 1 = 100 Mb/s
      logic full_dup;  // 1 = full duplex
      logic far_fault; // far-end fault seen
   } ppc_mac_stat_s;

   // decoded control levels toward one PHY
   typedef struct packed {
      logic tx_disable;
      logic an_restart;    // one-cycle pulse
      logic fef_enable;
      logic power_down;
      logic auto_mdix_off;
      logic force_mdi;
   } ppc_ctrl_s;

   // whole state of the register bank
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [1:0] strap_meta;
      logic [1:0] strap_sync;
      logic [1:0] strap_cnt;
      logic       strap_done;
      logic [7:0] rdata;
      logic       rvalid;
      logic [3:0] led1;
      logic [3:0] led2;
      ppc_ctrl_s  out1;
      ppc_ctrl_s  out2;
      logic [7:0] miim_ctrl;
      logic [7:0] miim_stat;
   } ppc_state_s;

endpackage

// ===== logic/ppc_port_regs.sv
`timescale 1ns/1ps

// Summary of operation
// RULE1: led off bit blanks port indicators
// RULE2: blanked indicators are all driven high
// RULE3: bit 6 disables port transmitter
// RULE4: writing bit 5 restarts auto-negotiation
// RULE5: bit 4 zero enables far-end fault
// RULE6: bit 3 powers down, port 1 only
// RULE7: bit 2 disables auto crossover; strap on port 2
// RULE8: bit 1 forces straight or crossover mode
// RULE9: bit 0 reserved, software keeps zero
// RULE10: status a bit 7 is crossover state
// RULE11: status a bit 6 is negotiation done
// RULE12: status a bit 5 is link good
// RULE13: status a bit 4 is partner pause
// RULE14: status a bits 3..0 partner abilities
// RULE15: status b bit 4 receive flow control
// RULE16: status b bit 3 transmit flow control
// RULE17: status b bit 2 is 100 Mb/s speed
// RULE18: status b bit 1 is full duplex
// RULE19: status b bit 0 far-end fault, port 1
// RULE20: status b exists for all three ports
// RULE21: port 3 control and status a reserved
// RULE22: control and status a mirrored to management
// RULE23: restart bit self-clears after launching
// RULE24: status is live, reads have no effect
module ppc_port_regs (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   // management register interface
   input  wire logic [7:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata,
   output logic                        reg_rvalid,
   // phy management mirror
   input  wire logic                   miim_port_sel,
   input  wire logic                   miim_ctrl_wr,
   input  wire logic [7:0]             miim_ctrl_wdata,
   output logic      [7:0]             miim_ctrl_rdata,
   output logic      [7:0]             miim_stat_rdata,
   // strap pins, sampled after reset release
   input  wire logic                   port2_crossover_auto_off_strap,
   input  wire logic                   port2_crossover_force_strap,
   // live port state
   input  wire ppc_pkg::ppc_phy_stat_s port1_phy_stat,
   input  wire ppc_pkg::ppc_phy_stat_s port2_phy_stat,
   input  wire ppc_pkg::ppc_mac_stat_s port1_mac_stat,
   input  wire ppc_pkg::ppc_mac_stat_s port2_mac_stat,
   input  wire ppc_pkg::ppc_mac_stat_s port3_mac_stat,
   // indicator drive from the led logic
   input  wire logic [3:0]             port1_led_raw,
   input  wire logic [3:0]             port2_led_raw,
   // indicator pins
   output logic      [3:0]             port1_indicator_out,
   output logic      [3:0]             port2_indicator_out,
   // control levels toward the phys
   output ppc_pkg::ppc_ctrl_s          port1_phy_ctrl,
   output ppc_pkg::ppc_ctrl_s          port2_phy_ctrl
);

   ppc_pkg::ppc_state_s st_r;   // all registered state
   ppc_pkg::ppc_state_s st_nxt; // next value of the state

   // first status byte from live phy state
   function automatic logic [7:0] stat_a(input ppc_pkg::ppc_phy_stat_s p);
      stat_a = {p.mdix,                 // [RULE10]
                p.an_done,              // [RULE11]
                p.link_good,            // [RULE12]
                p.partner_pause,        // [RULE13]
                p.partner_abil};        // [RULE14]
   endfunction

   // second status byte; fault only kept on the fiber port
   function automatic logic [7:0] stat_b(input ppc_pkg::ppc_mac_stat_s m,
                                         input logic fiber);
      stat_b = {3'h0,
                m.rx_fc,                // [RULE15]
                m.tx_fc,                // [RULE16]
                m.speed100,             // [RULE17]
                m.full_dup,             // [RULE18]
                m.far_fault & fiber};   // [RULE19]
   endfunction

   // decode a control byte into phy levels
   function automatic ppc_pkg::ppc_ctrl_s decode(input logic [7:0] c,
                                                 input logic restart,
                                                 input logic fiber);
      decode.tx_disable    = c[ppc_pkg::CTL_TX_DISABLE];        // [RULE3]
      decode.an_restart    = restart;                           // [RULE4]
      decode.fef_enable    = ~c[ppc_pkg::CTL_FEF_DISABLE];      // [RULE5]
      // only the fiber port can be powered down
      decode.power_down    = c[ppc_pkg::CTL_POWER_DOWN] & fiber; // [RULE6]
      decode.auto_mdix_off = c[ppc_pkg::CTL_MDIX_OFF];          // [RULE7]
      // force value only matters while auto crossover is off
      decode.force_mdi     = c[ppc_pkg::CTL_FORCE_MDI];         // [RULE8]
   endfunction

   // store a written control byte; restart never stays set
   function automatic logic [7:0] store(input logic [7:0] w);
      store = w;
      store[ppc_pkg::CTL_AN_RESTART] = 1'b0;                   // [RULE23]
   endfunction

   // indicator pins, blanked high when led off is set
   function automatic logic [3:0] led(input logic [7:0] c,
                                      input logic [3:0] raw);
      if (c[ppc_pkg::CTL_LED_OFF]) begin
         led = ppc_pkg::LED_DARK;                              // [RULE1] [RULE2]
      end else begin
         led = raw;
      end
   endfunction

   // next-state logic
   always_comb begin
      logic       wr1;     // register write to port 1 control
      logic       wr2;     // register write to port 2 control
      logic       mwr1;    // mirror write to port 1 control
      logic       mwr2;    // mirror write to port 2 control
      logic       rst1;    // restart request port 1
      logic       rst2;    // restart request port 2
      logic [7:0] mctl;    // control byte seen by the mirror
      wr1  = 1'b0;
      wr2  = 1'b0;
      mwr1 = 1'b0;
      mwr2 = 1'b0;
      rst1 = 1'b0;
      rst2 = 1'b0;
      mctl = 8'h00;
      st_nxt = st_r;

      // strap synchroniser; counter waits for clean samples
      st_nxt.strap_meta = {port2_crossover_auto_off_strap,
                           port2_crossover_force_strap};
      st_nxt.strap_sync = st_r.strap_meta;
      if (!st_r.strap_done) begin
         if (st_r.strap_cnt == ppc_pkg::STRAP_SETTLE) begin
            // load port 2 crossover defaults from the straps once
            st_nxt.strap_done = 1'b1;
            st_nxt.ctrl2[ppc_pkg::CTL_MDIX_OFF]  = st_r.strap_sync[1]; // [RULE7]
            st_nxt.ctrl2[ppc_pkg::CTL_FORCE_MDI] = st_r.strap_sync[0]; // [RULE8]
         end else begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
         end
      end

      // writes are held off until the strap defaults are in,
      // so an early write cannot be overwritten by the straps
      if (st_r.strap_done) begin
         wr1  = reg_wr && reg_addr == ppc_pkg::PORT1_PHY_CONTROL_OFS;
         wr2  = reg_wr && reg_addr == ppc_pkg::PORT2_PHY_CONTROL_OFS;
         // register bus wins over the mirror in the same cycle
         mwr1 = miim_ctrl_wr && !miim_port_sel && !reg_wr;     // [RULE22]
         mwr2 = miim_ctrl_wr && miim_port_sel && !reg_wr;      // [RULE22]
      end

      // control byte updates; reserved bit 0 stored as written
      if (wr1) begin
         st_nxt.ctrl1 = store(reg_wdata);                      // [RULE9]
         rst1 = reg_wdata[ppc_pkg::CTL_AN_RESTART];
      end else if (mwr1) begin
         st_nxt.ctrl1 = store(miim_ctrl_wdata);
         rst1 = miim_ctrl_wdata[ppc_pkg::CTL_AN_RESTART];
      end
      if (wr2) begin
         st_nxt.ctrl2 = store(reg_wdata);                      // [RULE9]
         rst2 = reg_wdata[ppc_pkg::CTL_AN_RESTART];
      end else if (mwr2) begin
         st_nxt.ctrl2 = store(miim_ctrl_wdata);
         rst2 = miim_ctrl_wdata[ppc_pkg::CTL_AN_RESTART];
      end

      // phy controls follow the new byte without extra lag
      st_nxt.out1 = decode(st_nxt.ctrl1, rst1, 1'b1);          // [RULE4]
      st_nxt.out2 = decode(st_nxt.ctrl2, rst2, 1'b0);
      st_nxt.led1 = led(st_nxt.ctrl1, port1_led_raw);
      st_nxt.led2 = led(st_nxt.ctrl2, port2_led_raw);

      // register read; status comes live, reads change nothing
      st_nxt.rvalid = reg_rd;
      st_nxt.rdata  = ppc_pkg::STATUS_RESET;
      if (reg_rd) begin
         unique case (reg_addr)
            ppc_pkg::PORT1_PHY_CONTROL_OFS: begin
               st_nxt.rdata = st_r.ctrl1;
            end
            ppc_pkg::PORT1_LINK_STATUS_A_OFS: begin
               st_nxt.rdata = stat_a(port1_phy_stat);          // [RULE24]
            end
            ppc_pkg::PORT1_LINK_STATUS_B_OFS: begin
               st_nxt.rdata = stat_b(port1_mac_stat, 1'b1);    // [RULE20]
            end
            ppc_pkg::PORT2_PHY_CONTROL_OFS: begin
               st_nxt.rdata = st_r.ctrl2;
            end
            ppc_pkg::PORT2_LINK_STATUS_A_OFS: begin
               st_nxt.rdata = stat_a(port2_phy_stat);          // [RULE24]
            end
            ppc_pkg::PORT2_LINK_STATUS_B_OFS: begin
               st_nxt.rdata = stat_b(port2_mac_stat, 1'b0);    // [RULE20]
            end
            ppc_pkg::PORT3_LINK_STATUS_B_OFS: begin
               st_nxt.rdata = stat_b(port3_mac_stat, 1'b0);    // [RULE20]
            end
            // port 3 has no phy: its slots read zero
            ppc_pkg::PORT3_CONTROL_SLOT_OFS,
            ppc_pkg::PORT3_STATUS_A_SLOT_OFS: begin
               st_nxt.rdata = ppc_pkg::STATUS_RESET;           // [RULE21]
            end
            // unmapped addresses also read zero
            default: begin
               st_nxt.rdata = ppc_pkg::STATUS_RESET;
            end
         endcase
      end

      // mirror view of the selected port, refreshed every cycle
      if (miim_port_sel) begin
         mctl = st_r.ctrl2;
         st_nxt.miim_stat = stat_a(port2_phy_stat);            // [RULE22]
      end else begin
         mctl = st_r.ctrl1;
         st_nxt.miim_stat = stat_a(port1_phy_stat);            // [RULE22]
      end
      st_nxt.miim_ctrl = mctl;
   end

   // state register; asynchronous reset to constants only
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '{ctrl1:      ppc_pkg::CONTROL_RESET,
                    ctrl2:      ppc_pkg::CONTROL_RESET,
                    strap_meta: 2'h0,
                    strap_sync: 2'h0,
                    strap_cnt:  2'h0,
                    strap_done: 1'b0,
                    rdata:      ppc_pkg::STATUS_RESET,
                    rvalid:     1'b0,
                    led1:       4'h0,
                    led2:       4'h0,
                    out1:       '{fef_enable: 1'b1, default: 1'b0},
                    out2:       '{fef_enable: 1'b1, default: 1'b0},
                    miim_ctrl:  ppc_pkg::CONTROL_RESET,
                    miim_stat:  ppc_pkg::STATUS_RESET};
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output straight from the state register
   assign reg_rdata           = st_r.rdata;
   assign reg_rvalid          = st_r.rvalid;
   assign miim_ctrl_rdata     = st_r.miim_ctrl;
   assign miim_stat_rdata     = st_r.miim_stat;
   assign port1_indicator_out = st_r.led1;
   assign port2_indicator_out = st_r.led2;
   assign port1_phy_ctrl      = st_r.out1;
   assign port2_phy_ctrl      = st_r.out2;

endmodule

// ===== verif/ppc_port_regs_assertions.sv
`timescale 1ns/1ps

module ppc_port_regs_chk (
   // clock and reset
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   // register bus
   input wire logic [7:0]         reg_addr,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [7:0]         reg_wdata,
   input wire logic [7:0]         reg_rdata,
   input wire logic               reg_rvalid,
   // indicators and phy controls
   input wire logic [3:0]         port1_led_raw,
   input wire logic [3:0]         port1_indicator_out,
   input wire ppc_pkg::ppc_ctrl_s port1_phy_ctrl,
   input wire ppc_pkg::ppc_ctrl_s port2_phy_ctrl
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // write strobes toward each control byte
   wire logic wr_ctl1;
   wire logic wr_ctl2;
   assign wr_ctl1 = reg_wr && reg_addr == 8'h1d;
   assign wr_ctl2 = reg_wr && reg_addr == 8'h2d;

   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe got no valid answer");
   a_rdata_idle_zero: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_led_blank_high: assert property
      (wr_ctl1 && reg_wdata[7] |=> port1_indicator_out == 4'hf)
      else $error("indicators not driven high when blanked");
   a_led_follow_raw: assert property
      (wr_ctl1 && !reg_wdata[7] |=> ##1
       port1_indicator_out == $past(port1_led_raw))
      else $error("indicators do not follow led drive");
   a_restart_pulse: assert property
      (wr_ctl1 && reg_wdata[5] |=> port1_phy_ctrl.an_restart ##1
       !port1_phy_ctrl.an_restart)
      else $error("restart is not a single pulse");
   a_tx_fef_follow: assert property
      (wr_ctl1 |=> port1_phy_ctrl.tx_disable == $past(reg_wdata[6]) &&
       port1_phy_ctrl.fef_enable != $past(reg_wdata[4]))
      else $error("port 1 transmit or fault control wrong");
   a_pd_port1_only: assert property
      (!port2_phy_ctrl.power_down)
      else $error("port 2 power down driven");
   a_crossover_fields: assert property
      (wr_ctl2 |=> port2_phy_ctrl.auto_mdix_off == $past(reg_wdata[2]) &&
       port2_phy_ctrl.force_mdi == $past(reg_wdata[1]))
      else $error("port 2 crossover control wrong");

   // main scenarios reached
   c_restart: cover property (wr_ctl1 && reg_wdata[5]);
   c_read: cover property (reg_rvalid);
   c_blank: cover property (port1_indicator_out == 4'hf);
endmodule

bind ppc_port_regs ppc_port_regs_chk u_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .port1_led_raw(port1_led_raw),
   .port1_indicator_out(port1_indicator_out),
   .port1_phy_ctrl(port1_phy_ctrl), .port2_phy_ctrl(port2_phy_ctrl));

// ===== verif/testbench.sv
`timescale 1ns/1ps

module testbench;
   // stimulus, driven on the rising edge
   logic                   sys_clk = 1'b0;
   logic                   sys_rst = 1'b1;
   logic [7:0]             reg_addr = 8'h00, reg_wdata = 8'h00;
   logic                   reg_wr = 1'b0, reg_rd = 1'b0;
   logic                   miim_sel = 1'b0, miim_wr = 1'b0;
   logic [7:0]             miim_wdata = 8'h00;
   logic                   strap_off = 1'b1, strap_force = 1'b1;
   ppc_pkg::ppc_phy_stat_s phy1 = 8'h00, phy2 = 8'h00;
   ppc_pkg::ppc_mac_stat_s mac1 = 5'h00, mac2 = 5'h00, mac3 = 5'h00;
   logic [3:0]             led1 = 4'h5, led2 = 4'ha;
   // observed outputs
   logic [7:0]             reg_rdata, miim_crd, miim_srd;
   logic                   reg_rvalid;
   logic [3:0]             ind1, ind2;
   ppc_pkg::ppc_ctrl_s     ctl1, ctl2;
   int                     error_cnt = 0, n_compared = 0, cyc = 0;

   ppc_port_regs u_ppc_port_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .miim_port_sel(miim_sel), .miim_ctrl_wr(miim_wr),
      .miim_ctrl_wdata(miim_wdata), .miim_ctrl_rdata(miim_crd),
      .miim_stat_rdata(miim_srd),
      .port2_crossover_auto_off_strap(strap_off),
      .port2_crossover_force_strap(strap_force),
      .port1_phy_stat(phy1), .port2_phy_stat(phy2), .port1_mac_stat(mac1),
      .port2_mac_stat(mac2), .port3_mac_stat(mac3), .port1_led_raw(led1),
      .port2_led_raw(led2), .port1_indicator_out(ind1),
      .port2_indicator_out(ind2), .port1_phy_ctrl(ctl1),
      .port2_phy_ctrl(ctl2));

   // 50 MHz clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   // hang guard, the tests need about 130 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // compare one byte, count it, report a mismatch
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle write strobe; returns just after the effect edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe; answer stands only in the next cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
      chk("rdata", reg_rdata, exp);
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // writes are dropped until the straps are loaded
      repeat (4) @(posedge sys_clk);
      rd(8'h1d, 8'h00);
      rd(8'h2d, 8'h06);
      chk("fef", {7'h00, ctl1.fef_enable}, 8'h01);
      $display("test reset done");
      // every control bit set: restart must not stick
      wr(8'h1d, 8'hff);
      chk("ctl1", {2'h0, ctl1}, 8'h37);
      chk("ind1", {4'h0, ind1}, 8'h0f);
      @(posedge sys_clk);
      #1;
      chk("rst1", {7'h00, ctl1.an_restart}, 8'h00);
      rd(8'h1d, 8'hdf);
      wr(8'h1d, 8'h00);
      chk("ctl1", {2'h0, ctl1}, 8'h08);
      @(posedge sys_clk);
      #1;
      chk("ind1", {4'h0, ind1}, {4'h0, led1});
      wr(8'h2d, 8'hff);
      chk("ctl2", {2'h0, ctl2}, 8'h33);
      chk("ind2", {4'h0, ind2}, 8'h0f);
      $display("test control done");
      // walking one over both status bytes
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         phy1 <= 8'h01 << i;
         phy2 <= 8'h80 >> i;
         rd(8'h1e, 8'h01 << i);
         rd(8'h2e, 8'h80 >> i);
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         mac1 <= 5'h01 << i;
         mac2 <= 5'h01 << i;
         mac3 <= 5'h01 << i;
         rd(8'h1f, 8'h01 << i);
         rd(8'h2f, (i == 0) ? 8'h00 : 8'h01 << i);
         rd(8'h3f, (i == 0) ? 8'h00 : 8'h01 << i);
      end
      rd(8'h1e, 8'h80);
      rd(8'h1e, 8'h80);
      $display("test status done");
      // reserved slots and an unmapped address
      wr(8'h3d, 8'hff);
      wr(8'h1e, 8'hff);
      rd(8'h3d, 8'h00);
      rd(8'h3e, 8'h00);
      rd(8'h77, 8'h00);
      rd(8'h1d, 8'h00);
      $display("test reserved done");
      // mirror write to port 2, then readback lags a cycle
      @(posedge sys_clk);
      miim_sel   <= 1'b1;
      miim_wdata <= 8'h40;
      miim_wr    <= 1'b1;
      @(posedge sys_clk);
      miim_wr <= 1'b0;
      #1;
      chk("ctl2", {2'h0, ctl2}, 8'h28);
      @(posedge sys_clk);
      #1;
      chk("mctl", miim_crd, 8'h40);
      chk("msta", miim_srd, 8'h01);
      rd(8'h2d, 8'h40);
      // port 1 mirror write loses to a register write in one cycle
      @(posedge sys_clk);
      miim_sel   <= 1'b0;
      miim_wdata <= 8'h40;
      miim_wr    <= 1'b1;
      reg_addr   <= 8'h1d;
      reg_wdata  <= 8'h06;
      reg_wr     <= 1'b1;
      @(posedge sys_clk);
      miim_wr <= 1'b0;
      reg_wr  <= 1'b0;
      #1;
      chk("ctl1", {2'h0, ctl1}, 8'h0b);
      chk("ind1", {4'h0, ind1}, 8'h05);
      chk("ind2", {4'h0, ind2}, 8'h0a);
      @(posedge sys_clk);
      #1;
      chk("mctl", miim_crd, 8'h06);
      chk("msta", miim_srd, 8'h80);
      rd(8'h1d, 8'h06);
      $display("test mirror done");
      tally_and_finish();
   end
endmodule
